// [src/window_timeout_watchdog.sv]
// Window and time-out watchdog with stop-mode disable, failure counter and reset output.
`timescale 1ns/10ps

// Notes on behaviour
// - Time-out and window types chosen by a select bit; time-out after reset.
// - Type and period only change in normal mode; stop mode keeps them.
// - Init starts long window at reset release; sleep and restart keep watchdog off.
// - A valid control write at chip select rise triggers and restarts the timer.
// - Long open window of 200 ms after init, restart or stop re-enable.
// - Period settings 1 to 7 give 10 to 1000 ms for both types.
// - Failure requests restart or fail-safe; reset release starts long window, asks normal.
// - Development mode keeps the watchdog off and blocks its reset; the bus wake interrupt still fires.
// - Each bad service increments failure counter, saturating 01 or 10 by config.
// - Failure counter clears on good trigger, in stop-off and sleep, and in fail-safe not entered by the watchdog.
// - Time-out type accepts a trigger anywhere and restarts a full period.
// - Time-out expiry drives reset low and requests restart or fail-safe.
// - Window type: closed window 60 percent, open window centred on the period.
// - Trigger in closed window or window expiry forces reset and mode change.
// - Control byte needs even parity; bad parity is ignored and flags failure.
// - Parity covers all eight written bits including reserved bit 3.
// - Stop disable needs two bits set in sequence; errors clear the second bit.
// - First disable bit already set when sequence starts is cleared automatically.
// - Trigger in stop or return to normal re-enables with long window, clears bits.
// - Bus wake restart bit, default one, writable in normal mode only.
// - CAN wake restarts watchdog, raises interrupt and pulls receive line low.
// - Reset output stays low while the event lasts plus the reset delay.
module window_timeout_watchdog
    import window_watchdog_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire sbc_mode_type     chip_mode,
    input  wire logic             development_mode,
    input  wire logic [1:0]       fail_config,
    input  wire logic             fail_to_failsafe,
    input  wire logic             ext_reset_event,
    input  wire config_write_type cfg_write,
    input  wire wake_write_type   wake_write,
    input  wire logic             can_wake,
    input  wire logic             spi_fail_clear,
    output logic                  reset_output_pin,
    output logic                  restart_request,
    output logic                  failsafe_request,
    output logic                  normal_request,
    output logic [1:0]            failure_counter,
    output logic                  spi_fail,
    output logic                  window_type_select,
    output logic [2:0]            period_select_field,
    output logic                  stop_disable_first_bit,
    output logic                  stop_disable_second_bit,
    output logic                  bus_wake_restart_enable,
    output logic                  wake_interrupt,
    output logic                  can_rxd_pull_low,
    output wd_state_type          wd_state
);

    logic [9:0]       tick_cnt_reg;
    logic             tick_reg;
    logic [15:0]      timer_reg;
    logic [15:0]      delay_cnt_reg;
    logic             fail_reg;
    logic             wd_caused_reset_reg;
    logic             entered_by_wd_reg;
    sbc_mode_type     prev_mode_reg;

    logic             parity_ok;
    logic             cfg_valid;
    logic             is_normal;
    logic             is_stop;
    logic             stop_off;
    logic             trigger;
    logic             cfg_allowed;
    logic             next_window;
    logic [2:0]       next_period;
    logic [15:0]      cur_period;
    logic [15:0]      closed_ticks;
    logic [15:0]      open_end_ticks;
    logic             reenable;
    logic             bus_restart;
    logic             wd_off;
    logic             fail_now;
    logic             reset_hold;

    assign parity_ok   = ~^cfg_write.data;
    assign cfg_valid   = cfg_write.valid & parity_ok;
    assign is_normal   = (chip_mode == MODE_NORMAL);
    assign is_stop     = (chip_mode == MODE_STOP);
    assign stop_off    = is_stop & stop_disable_first_bit & stop_disable_second_bit;
    assign trigger     = cfg_valid & (is_normal | is_stop | chip_mode == MODE_INIT);
    assign cfg_allowed = cfg_valid & is_normal;
    assign next_window = cfg_allowed ? cfg_write.data[CFG_WINDOW_BIT] : window_type_select;
    assign next_period = cfg_allowed ? cfg_write.data[CFG_PERIOD_LSB +: CFG_PERIOD_WIDTH]
                                     : period_select_field;
    assign cur_period  = period_ticks(period_select_field);
    assign closed_ticks   = 16'((32'(cur_period) * CLOSED_WINDOW_PERCENT) / 100);
    assign open_end_ticks = 16'((32'(cur_period) * OPEN_WINDOW_END_PERCENT) / 100);
    assign reenable    = (stop_off & trigger) | (is_normal & prev_mode_reg == MODE_STOP
                       & stop_disable_first_bit & stop_disable_second_bit);
    assign bus_restart = stop_off & can_wake & bus_wake_restart_enable;
    // Reset output low covers restart mode, so no separate check is needed for it.
    assign wd_off      = development_mode | stop_off | ~reset_output_pin
                       | chip_mode == MODE_SLEEP | chip_mode == MODE_FAILSAFE;
    assign reset_hold  = fail_reg | ext_reset_event;

    always_comb begin
        fail_now = 1'b0;
        case (wd_state)
            WD_LONG:   fail_now = ~trigger & tick_reg & (timer_reg >= 16'(LONG_WINDOW_TICKS - 1));
            WD_CLOSED: fail_now = trigger;
            WD_OPEN: begin
                if (window_type_select) begin
                    fail_now = ~trigger & tick_reg & (timer_reg >= open_end_ticks - 16'h0001);
                end else begin
                    fail_now = ~trigger & tick_reg & (timer_reg >= cur_period - 16'h0001);
                end
            end
            default:   fail_now = 1'b0;
        endcase
        if (wd_off) begin
            fail_now = 1'b0;
        end
    end

    // One prescaled tick feeds every window, so all windows keep the same ratio on drift.
    always_ff @(posedge mclk) begin
        if (rst) begin
            tick_cnt_reg <= 10'h000;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg == 10'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= 10'h000;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 10'h001;
            tick_reg     <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            window_type_select  <= WINDOW_TYPE_RESET;
            period_select_field <= PERIOD_RESET;
        end else if (cfg_allowed) begin
            window_type_select  <= next_window;
            period_select_field <= next_period;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wd_state  <= WD_OFF;
            timer_reg <= 16'h0000;
        end else if (wd_off || fail_now) begin
            wd_state  <= WD_OFF;
            timer_reg <= 16'h0000;
        end else if (wd_state == WD_OFF) begin
            // Leaving reset, init, a stop re-enable or a bus wake all land here.
            wd_state  <= WD_LONG;
            timer_reg <= 16'h0000;
        end else if (trigger) begin
            wd_state  <= next_window ? WD_CLOSED : WD_OPEN;
            timer_reg <= 16'h0000;
        end else if (wd_state == WD_CLOSED && tick_reg && timer_reg >= closed_ticks - 16'h0001) begin
            wd_state  <= WD_OPEN;
            timer_reg <= timer_reg + 16'h0001;
        end else if (tick_reg) begin
            timer_reg <= timer_reg + 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            fail_reg         <= 1'b0;
            restart_request  <= 1'b0;
            failsafe_request <= 1'b0;
        end else begin
            fail_reg         <= fail_now;
            restart_request  <= fail_now & ~fail_to_failsafe;
            failsafe_request <= fail_now & fail_to_failsafe;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            failure_counter <= 2'h0;
        end else if (fail_now) begin
            if (fail_config == FAIL_CONFIG_TWO) begin
                if (failure_counter < FAIL_SAT_CFG_TWO) begin
                    failure_counter <= failure_counter + 2'h1;
                end
            end else if (failure_counter < FAIL_SAT_OTHER) begin
                failure_counter <= failure_counter + 2'h1;
            end
        end else if ((trigger && wd_state != WD_OFF) || stop_off || chip_mode == MODE_SLEEP
                     || (chip_mode == MODE_FAILSAFE && !entered_by_wd_reg)) begin
            failure_counter <= 2'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            entered_by_wd_reg <= 1'b0;
        end else if (fail_now) begin
            entered_by_wd_reg <= 1'b1;
        end else if (is_normal) begin
            entered_by_wd_reg <= 1'b0;
        end
    end

    // The delay runs only after the cause has gone, so a long cause stretches the pulse.
    always_ff @(posedge mclk) begin
        if (rst) begin
            reset_output_pin <= 1'b0;
            delay_cnt_reg    <= 16'h0000;
        end else if (reset_hold) begin
            reset_output_pin <= 1'b0;
            delay_cnt_reg    <= 16'h0000;
        end else if (!reset_output_pin && tick_reg) begin
            if (delay_cnt_reg >= 16'(RESET_DELAY_TICKS - 1)) begin
                reset_output_pin <= 1'b1;
            end else begin
                delay_cnt_reg <= delay_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wd_caused_reset_reg <= 1'b0;
            normal_request      <= 1'b0;
        end else begin
            normal_request <= 1'b0;
            if (fail_reg) begin
                wd_caused_reset_reg <= 1'b1;
            end else if (wd_caused_reset_reg && !reset_hold && !reset_output_pin && tick_reg
                         && delay_cnt_reg >= 16'(RESET_DELAY_TICKS - 1)) begin
                wd_caused_reset_reg <= 1'b0;
                normal_request      <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            spi_fail <= 1'b0;
        end else if (cfg_write.valid && !parity_ok) begin
            spi_fail <= 1'b1;
        end else if (spi_fail_clear) begin
            spi_fail <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            bus_wake_restart_enable <= BUS_WAKE_RESET;
        end else if (wake_write.valid && is_normal) begin
            bus_wake_restart_enable <= wake_write.bus_wake;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            stop_disable_first_bit  <= 1'b0;
            stop_disable_second_bit <= 1'b0;
        end else if (reenable || bus_restart) begin
            stop_disable_first_bit  <= 1'b0;
            stop_disable_second_bit <= 1'b0;
        end else if (wake_write.valid && is_normal) begin
            stop_disable_second_bit <= 1'b0;
            if (wake_write.first_bit) begin
                stop_disable_first_bit <= ~stop_disable_first_bit;
            end else begin
                stop_disable_first_bit <= 1'b0;
            end
        end else if (cfg_allowed) begin
            if (cfg_write.data[CFG_STOP_DISABLE_BIT] && stop_disable_first_bit) begin
                stop_disable_second_bit <= 1'b1;
            end else begin
                // Out-of-order or intervening write: the host must begin again.
                stop_disable_second_bit <= 1'b0;
                stop_disable_first_bit  <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_interrupt   <= 1'b0;
            can_rxd_pull_low <= 1'b0;
        end else begin
            wake_interrupt <= bus_restart;
            if (bus_restart) begin
                can_rxd_pull_low <= 1'b1;
            end else if (trigger || is_normal) begin
                can_rxd_pull_low <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            prev_mode_reg <= MODE_INIT;
        end else begin
            prev_mode_reg <= chip_mode;
        end
    end

endmodule // window_timeout_watchdog

// [src/window_watchdog_pkg.sv]
// Constants, field layout and types shared by the window and time-out watchdog.
package window_watchdog_pkg;

    // Timebase: one prescaled tick of the internal oscillator.
    localparam int CLOCK_MHZ             = 10;
    localparam int TICK_TIME_US          = 100;
    localparam int TICK_CYCLES           = TICK_TIME_US * CLOCK_MHZ;
    localparam int TICKS_PER_MS          = 1000 / TICK_TIME_US;

    // Window timing.
    localparam int LONG_OPEN_WINDOW_TIME_MS = 200;
    localparam int LONG_WINDOW_TICKS        = LONG_OPEN_WINDOW_TIME_MS * TICKS_PER_MS;
    localparam int RESET_DELAY_TIME_MS      = 1;
    localparam int RESET_DELAY_TICKS        = RESET_DELAY_TIME_MS * TICKS_PER_MS;
    localparam int CLOSED_WINDOW_PERCENT    = 60;
    localparam int OPEN_WINDOW_END_PERCENT  = 140;
    localparam int PERIOD_MS_TABLE [8]      = '{10, 10, 20, 50, 100, 200, 500, 1000};

    // Field positions in the watchdog control byte.
    localparam int CFG_CHECKSUM_BIT      = 7;
    localparam int CFG_STOP_DISABLE_BIT  = 6;
    localparam int CFG_WINDOW_BIT        = 5;
    localparam int CFG_RESERVED_BIT      = 3;
    localparam int CFG_PERIOD_LSB        = 0;
    localparam int CFG_PERIOD_WIDTH      = 3;

    // Reset values and saturation limits.
    localparam logic       WINDOW_TYPE_RESET = 1'h0;
    localparam logic [2:0] PERIOD_RESET      = 3'h1;
    localparam logic       BUS_WAKE_RESET    = 1'h1;
    localparam logic [1:0] FAIL_CONFIG_TWO   = 2'h1;
    localparam logic [1:0] FAIL_SAT_CFG_TWO  = 2'h1;
    localparam logic [1:0] FAIL_SAT_OTHER    = 2'h2;

    typedef enum logic [2:0] {
        MODE_INIT,
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_RESTART,
        MODE_FAILSAFE
    } sbc_mode_type;

    typedef enum logic [1:0] {
        WD_OFF,
        WD_LONG,
        WD_CLOSED,
        WD_OPEN
    } wd_state_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } config_write_type;

    typedef struct packed {
        logic valid;
        logic first_bit;
        logic bus_wake;
    } wake_write_type;

    function automatic logic [15:0] period_ticks(input logic [2:0] sel);
        period_ticks = 16'(PERIOD_MS_TABLE[sel] * TICKS_PER_MS);
    endfunction

endpackage

// [testbench/window_watchdog_sva.sv]
// Checker for the watchdog's port behaviour.
`timescale 1ns/10ps
module window_watchdog_sva
    import window_watchdog_pkg::*;
(
    input logic             mclk,
    input logic             rst,
    input sbc_mode_type     chip_mode,
    input logic             development_mode,
    input logic [1:0]       fail_config,
    input logic             ext_reset_event,
    input config_write_type cfg_write,
    input wake_write_type   wake_write,
    input logic             reset_output_pin,
    input logic             restart_request,
    input logic             failsafe_request,
    input logic [1:0]       failure_counter,
    input logic             spi_fail,
    input logic             window_type_select,
    input logic [2:0]       period_select_field,
    input logic             stop_disable_second_bit,
    input logic             stop_disable_first_bit,
    input logic             bus_wake_restart_enable,
    input wd_state_type     wd_state
);
    logic good;
    logic bad;
    logic fail;
    assign good = cfg_write.valid && !(^cfg_write.data);
    assign bad  = cfg_write.valid && (^cfg_write.data);
    assign fail = restart_request || failsafe_request;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_parity_sets_fail: assert property (bad |=> spi_fail)
        else $error("bad checksum did not flag");
    a_config_by_write: assert property ($changed(period_select_field)
        || $changed(window_type_select) |-> $past(good && chip_mode == MODE_NORMAL))
        else $error("config changed without accepted write");
    a_write_loads: assert property (good && chip_mode == MODE_NORMAL |=>
        period_select_field == $past(cfg_write.data[2:0])
        && window_type_select == $past(cfg_write.data[5]))
        else $error("config write not loaded");
    a_closed_hit_fails: assert property (good && wd_state == WD_CLOSED
        && chip_mode == MODE_NORMAL && !development_mode |-> ##[1:3] fail)
        else $error("closed window trigger not failed");
    a_fail_drops_reset: assert property (fail |-> ##[0:2] !reset_output_pin)
        else $error("failure did not drop reset");
    a_fail_counts: assert property (fail |-> ##[0:1] failure_counter != 2'h0)
        else $error("failure not counted");
    a_fail_saturates: assert property (failure_counter <=
        (fail_config == FAIL_CONFIG_TWO ? FAIL_SAT_CFG_TWO : FAIL_SAT_OTHER))
        else $error("failure counter above limit");
    a_second_after_first: assert property ($rose(stop_disable_second_bit)
        |-> stop_disable_first_bit)
        else $error("second disable bit set out of order");
    a_bus_wake_normal: assert property ($changed(bus_wake_restart_enable)
        |-> $past(wake_write.valid && chip_mode == MODE_NORMAL))
        else $error("bus wake enable changed outside normal");
    a_ext_holds_reset: assert property (ext_reset_event |=> !reset_output_pin)
        else $error("reset released during event");
    a_stop_trigger_long: assert property (good && chip_mode == MODE_STOP
        && wd_state == WD_OFF && reset_output_pin |-> ##[1:3] wd_state == WD_LONG)
        else $error("stop trigger did not restart");

    c_failure: cover property (restart_request);
    c_closed_hit: cover property (good && wd_state == WD_CLOSED);
    c_disabled: cover property ($rose(stop_disable_second_bit));
endmodule // window_watchdog_sva

// [testbench/host_model.sv]
// Host model: control byte writes, wake register writes and bus wakes.
`timescale 1ns/10ps
module host_model
    import window_watchdog_pkg::*;
(
    input  logic             mclk,
    output config_write_type cfg_write,
    output wake_write_type   wake_write,
    output logic             can_wake
);
    initial begin
        cfg_write  = '0;
        wake_write = '0;
        can_wake   = 1'b0;
    end

    // A cleared good flag breaks the checksum on purpose.
    task automatic send_cfg(input logic [6:0] body, input logic good);
        logic [7:0] data;
        data = {(^body) ^ !good, body};
        @(negedge mclk);
        cfg_write <= '{1'b1, data};
        @(negedge mclk);
        // Released data is inverted so a stale byte never looks live.
        cfg_write <= '{1'b0, ~data};
    endtask

    task automatic send_wake(input logic first, input logic bus);
        @(negedge mclk);
        wake_write <= '{1'b1, first, bus};
        @(negedge mclk);
        wake_write <= '{1'b0, ~first, ~bus};
    endtask

    task automatic bus_wake();
        @(negedge mclk);
        can_wake <= 1'b1;
        @(negedge mclk);
        can_wake <= 1'b0;
    endtask
endmodule // host_model

// [testbench/test_window_timeout_watchdog.sv]
// Testbench for the window and time-out watchdog.
`timescale 1ns/10ps
module test_window_timeout_watchdog
    import window_watchdog_pkg::*;
;
    logic             mclk;
    logic             rst;
    sbc_mode_type     chip_mode;
    logic             ext_reset_event;
    logic             development_mode;
    logic             spi_fail_clear;
    config_write_type cfg_write;
    wake_write_type   wake_write;
    logic             can_wake;
    logic             reset_output_pin;
    logic             restart_request;
    logic [1:0]       failure_counter;
    logic             spi_fail;
    logic             window_type_select;
    logic [2:0]       period_select_field;
    logic             first_bit;
    logic             second_bit;
    logic             bus_wake_restart_enable;
    logic             wake_interrupt;
    logic             can_rxd_pull_low;
    wd_state_type     wd_state;
    int               errors;
    int               n_tests;
    int               cycles;
    int               n_restart;
    int               n_wake;

    window_timeout_watchdog window_timeout_watchdog_inst (
        .mclk(mclk), .rst(rst), .chip_mode(chip_mode), .development_mode(development_mode),
        .fail_config(2'h0), .fail_to_failsafe(1'b0), .ext_reset_event(ext_reset_event),
        .cfg_write(cfg_write), .wake_write(wake_write), .can_wake(can_wake),
        .spi_fail_clear(spi_fail_clear), .reset_output_pin(reset_output_pin),
        .restart_request(restart_request), .failsafe_request(), .normal_request(),
        .failure_counter(failure_counter), .spi_fail(spi_fail),
        .window_type_select(window_type_select), .period_select_field(period_select_field),
        .stop_disable_first_bit(first_bit), .stop_disable_second_bit(second_bit),
        .bus_wake_restart_enable(bus_wake_restart_enable), .wake_interrupt(wake_interrupt),
        .can_rxd_pull_low(can_rxd_pull_low), .wd_state(wd_state));

    host_model host_model_inst (
        .mclk(mclk), .cfg_write(cfg_write), .wake_write(wake_write), .can_wake(can_wake));

    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic disable_seq;
        chip_mode = MODE_NORMAL;
        host_model_inst.send_wake(1'b1, 1'b1);
        host_model_inst.send_cfg(7'h41, 1'b1);
        step(1);
        chk("second", 8'h1, 8'(second_bit));
        chip_mode = MODE_STOP;
        step(2);
        chk("state", 8'(WD_OFF), 8'(wd_state));
        chk("fails", 8'h0, 8'(failure_counter));
    endtask

    // The cycle limit covers the reset delay and one open-window wait of a short period.
    always @(posedge mclk) begin
        cycles++;
        if (restart_request === 1'b1) n_restart++;
        if (wake_interrupt === 1'b1) n_wake++;
        if (cycles == 99000) begin
            errors++;
            $display("wrong value cycle limit expected done seen hung");
            wrap_up();
        end
    end

    initial begin
        rst = 1'b1;
        chip_mode = MODE_INIT;
        ext_reset_event = 1'b0;
        development_mode = 1'b0;
        spi_fail_clear = 1'b0;
        step(3);
        chk("window", 8'h0, 8'(window_type_select));
        chk("period", 8'h1, 8'(period_select_field));
        chk("bus wake", 8'h1, 8'(bus_wake_restart_enable));
        chk("reset pin", 8'h0, 8'(reset_output_pin));
        rst = 1'b0;
        chip_mode = MODE_NORMAL;
        host_model_inst.send_cfg(7'h25, 1'b0);
        step(1);
        chk("spi fail", 8'h1, 8'(spi_fail));
        chk("period", 8'h1, 8'(period_select_field));
        spi_fail_clear = 1'b1;
        step(1);
        spi_fail_clear = 1'b0;
        step(1);
        chk("spi fail", 8'h0, 8'(spi_fail));
        for (int p = 1; p < 8; p++) begin
            host_model_inst.send_cfg({2'h1, 1'b0, 1'(p), 3'(p)}, 1'b1);
            step(1);
            chk("period", 8'(p), 8'(period_select_field));
            chk("window", 8'h1, 8'(window_type_select));
            chk("spi fail", 8'h0, 8'(spi_fail));
        end
        host_model_inst.send_cfg(7'h01, 1'b1);
        chip_mode = MODE_STOP;
        host_model_inst.send_cfg(7'h27, 1'b1);
        host_model_inst.send_wake(1'b0, 1'b0);
        step(1);
        chk("period", 8'h1, 8'(period_select_field));
        chk("bus wake", 8'h1, 8'(bus_wake_restart_enable));
        chip_mode = MODE_NORMAL;
        host_model_inst.send_wake(1'b0, 1'b0);
        step(1);
        chk("bus wake", 8'h0, 8'(bus_wake_restart_enable));
        host_model_inst.send_wake(1'b0, 1'b1);
        host_model_inst.send_cfg(7'h41, 1'b1);
        step(1);
        chk("second", 8'h0, 8'(second_bit));
        host_model_inst.send_wake(1'b1, 1'b1);
        host_model_inst.send_wake(1'b1, 1'b1);
        step(1);
        chk("first", 8'h0, 8'(first_bit));
        $display("test registers done");
        chip_mode = MODE_INIT;
        for (int i = 0; i < 20000 && reset_output_pin !== 1'b1; i++) step(1);
        step(2);
        chk("state", 8'(WD_LONG), 8'(wd_state));
        development_mode = 1'b1;
        step(2);
        chk("state", 8'(WD_OFF), 8'(wd_state));
        development_mode = 1'b0;
        step(2);
        chk("state", 8'(WD_LONG), 8'(wd_state));
        disable_seq();
        host_model_inst.bus_wake();
        step(3);
        chk("state", 8'(WD_LONG), 8'(wd_state));
        chk("rxd low", 8'h1, 8'(can_rxd_pull_low));
        chk("irq", 8'h1, 8'(n_wake));
        chk("first", 8'h0, 8'(first_bit));
        disable_seq();
        host_model_inst.send_cfg(7'h01, 1'b1);
        step(2);
        chk("state", 8'(WD_LONG), 8'(wd_state));
        chk("second", 8'h0, 8'(second_bit));
        disable_seq();
        chip_mode = MODE_NORMAL;
        step(2);
        chk("second", 8'h0, 8'(second_bit));
        chk("state", 8'(WD_LONG), 8'(wd_state));
        $display("test stop disable done");
        chip_mode = MODE_NORMAL;
        host_model_inst.send_cfg(7'h21, 1'b1);
        step(1);
        chk("state", 8'(WD_CLOSED), 8'(wd_state));
        // Waiting 0.8 of the period keeps the service clear of both window edges.
        step(PERIOD_MS_TABLE[1] * 1000 * CLOCK_MHZ * 8 / 10);
        chk("state", 8'(WD_OPEN), 8'(wd_state));
        host_model_inst.send_cfg(7'h21, 1'b1);
        step(1);
        chk("state", 8'(WD_CLOSED), 8'(wd_state));
        chk("restarts", 8'h0, 8'(n_restart));
        chk("fails", 8'h0, 8'(failure_counter));
        host_model_inst.send_cfg(7'h21, 1'b1);
        step(3);
        chk("restarts", 8'h1, 8'(n_restart));
        chk("fails", 8'h1, 8'(failure_counter));
        chk("reset pin", 8'h0, 8'(reset_output_pin));
        ext_reset_event = 1'b1;
        step(2);
        chk("reset pin", 8'h0, 8'(reset_output_pin));
        ext_reset_event = 1'b0;
        $display("test failure done");
        wrap_up();
    end
endmodule // test_window_timeout_watchdog

bind window_timeout_watchdog window_watchdog_sva window_watchdog_sva_inst (
    .mclk(mclk), .rst(rst), .chip_mode(chip_mode), .development_mode(development_mode),
    .fail_config(fail_config), .ext_reset_event(ext_reset_event), .cfg_write(cfg_write),
    .wake_write(wake_write), .reset_output_pin(reset_output_pin),
    .restart_request(restart_request), .failsafe_request(failsafe_request),
    .failure_counter(failure_counter), .spi_fail(spi_fail),
    .window_type_select(window_type_select), .period_select_field(period_select_field),
    .stop_disable_second_bit(stop_disable_second_bit),
    .stop_disable_first_bit(stop_disable_first_bit),
    .bus_wake_restart_enable(bus_wake_restart_enable), .wd_state(wd_state));
